// >>> bench/test_prescaled_timer_match_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_prescaled_timer_match_control;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [2:0]  match_flags;
  int          err_count = 0;
  int          checked = 0;
  logic [31:0] adr [9] = '{ptm_pkg::ADDR_FLAGS, ptm_pkg::ADDR_CTRL,
    ptm_pkg::ADDR_COUNT, ptm_pkg::ADDR_PLIM, ptm_pkg::ADDR_PCNT,
    ptm_pkg::ADDR_MCR, ptm_pkg::ADDR_MV0, ptm_pkg::ADDR_MV1,
    ptm_pkg::ADDR_MV2};

  always #25 hclk = ~hclk;

  ptm_timer u_ptm_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .hreadyout   (hreadyout),
    .hrdata      (hrdata),
    .hresp       (hresp),
    .match_flags (match_flags)
  );

  task automatic test_done;
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Expected counters after t counting edges from zero, limit p
  function automatic logic [31:0] exp_tc(input int t, input logic [31:0] p);
    return t / (p + 1);
  endfunction

  function automatic logic [31:0] exp_pc(input int t, input logic [31:0] p);
    return t % (p + 1);
  endfunction

  // Settled value at the falling edge is what the next rising edge samples
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge hclk);
    end
    if (n >= 20)
      chk(32'h1, 32'h0, "bus stuck");
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= ptm_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask

  // Enabled for w+5 counting edges; enable is read back mid-run
  task automatic run(input int w, input logic [31:0] en);
    wr(ptm_pkg::ADDR_CTRL, 32'h1);
    repeat (w) @(posedge hclk);
    rd(ptm_pkg::ADDR_CTRL, en, "enable");
    wr(ptm_pkg::ADDR_CTRL, 32'h0);
  endtask

  task automatic setup(input logic [31:0] t, input logic [31:0] p);
    wr(ptm_pkg::ADDR_MCR, 32'h0);
    wr(ptm_pkg::ADDR_COUNT, t);
    wr(ptm_pkg::ADDR_PCNT, 32'h0);
    wr(ptm_pkg::ADDR_PLIM, p);
  endtask

  initial
  begin
    logic [31:0] p;
    logic [31:0] m;
    logic [31:0] tex;
    int          w;
    int          t;
    void'($urandom(32'h026d99b1));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++)
      rd(adr[i], 32'h0, "reset value");
    wr(32'h4001_4024, 32'hffff_ffff);
    rd(32'h4001_4024, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++)
    begin
      p = (i < 2) ? i : $urandom_range(7, 2);
      if (i == 5)
        p = ($urandom & 32'h7fff_ffff) | 32'h100;
      w = $urandom_range(30, 0);
      t = w + 5;
      setup(32'h0, p);
      rd(ptm_pkg::ADDR_PLIM, p, "limit");
      run(w, 32'h1);
      rd(ptm_pkg::ADDR_COUNT, exp_tc(t, p), "count");
      rd(ptm_pkg::ADDR_PCNT, exp_pc(t, p), "prescale");
      repeat (10) @(posedge hclk);
      rd(ptm_pkg::ADDR_COUNT, exp_tc(t, p), "hold");
    end
    setup(ptm_pkg::COUNT_MAX, 32'h0);
    run(0, 32'h1);
    rd(ptm_pkg::ADDR_COUNT, 32'h4, "wrap");
    chk({29'h0, match_flags}, 32'h0, "wrap flags");
    rd(ptm_pkg::ADDR_FLAGS, 32'h0, "wrap flags");
    wr(ptm_pkg::ADDR_COUNT, 32'h5);
    wr(ptm_pkg::ADDR_PCNT, 32'h3);
    wr(ptm_pkg::ADDR_CTRL, 32'h2);
    rd(ptm_pkg::ADDR_COUNT, 32'h0, "counter_reset_bit count");
    wr(ptm_pkg::ADDR_CTRL, 32'h3);
    repeat (4) @(posedge hclk);
    rd(ptm_pkg::ADDR_PCNT, 32'h0, "counter_reset_bit prescale");
    rd(ptm_pkg::ADDR_COUNT, 32'h0, "counter_reset_bit count");
    wr(ptm_pkg::ADDR_CTRL, 32'h0);
    // Actions: 0 flag, 1 reset, 2 stop, 3 reset and stop
    for (int c = 0; c < 3; c++)
      for (int a = 0; a < 4; a++)
      begin
        m = $urandom_range(20, 7);
        setup(32'h0, 32'h0);
        wr(adr[6 + c], m);
        wr(ptm_pkg::ADDR_MCR, (a == 0) ? (32'h1 << (3 * c)) :
           (a == 3) ? (32'h6 << (3 * c)) : (32'h1 << (3 * c + a)));
        tex = (a == 0) ? m + 7 : (a == 1) ? 32'h6 : (a == 2) ? m : 32'h0;
        run(m + 2, (a >= 2) ? 32'h0 : 32'h1);
        rd(ptm_pkg::ADDR_COUNT, tex, "match count");
        rd(ptm_pkg::ADDR_PCNT, 32'h0, "match prescale");
        tex = (a == 0) ? (32'h1 << c) : 32'h0;
        chk({29'h0, match_flags}, tex, "flag pin");
        rd(ptm_pkg::ADDR_FLAGS, tex, "flag reg");
        wr(ptm_pkg::ADDR_FLAGS, 32'h0);
        rd(ptm_pkg::ADDR_FLAGS, tex, "write zero");
        wr(ptm_pkg::ADDR_FLAGS, 32'h7);
        rd(ptm_pkg::ADDR_FLAGS, 32'h0, "write one");
      end
    test_done();
  end

  // Far beyond the twelve hundred or so cycles the sequence needs at most
  initial
  begin
    #(50 * 30000);
    chk(32'h1, 32'h0, "timeout");
    test_done();
  end
endmodule // test_prescaled_timer_match_control
`default_nettype wire

// >>> src/ptm_match_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ptm_match_if;
  logic [31:0]                              tc;
  logic [ptm_pkg::NUM_MATCH-1:0][31:0]      mr;
  logic [ptm_pkg::MCR_WIDTH-1:0]            match_action_control;
  logic [ptm_pkg::NUM_MATCH-1:0]            prev;
  logic [ptm_pkg::NUM_MATCH-1:0]            eq;
  logic [ptm_pkg::NUM_MATCH-1:0]            irq_set;
  logic                                     reset_hit;
  logic                                     stop_hit;

  modport core (output tc, mr, match_action_control, prev,
                input  eq, irq_set, reset_hit, stop_hit);
  modport unit (input  tc, mr, match_action_control, prev,
                output eq, irq_set, reset_hit, stop_hit);
endinterface
`default_nettype wire

// >>> src/ptm_match_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_match_unit (
  ptm_match_if.unit mif
);

  logic [ptm_pkg::NUM_MATCH-1:0] fire;
  logic [ptm_pkg::NUM_MATCH-1:0] rst_v;
  logic [ptm_pkg::NUM_MATCH-1:0] stop_v;

  for (genvar i = 0; i < ptm_pkg::NUM_MATCH; i++)
  begin : g_ch
    localparam int unsigned B = i * ptm_pkg::MCR_STRIDE;
    assign mif.eq[i] = (mif.mr[i] == mif.tc);
    // Act once on entry to equality, so a cleared flag stays cleared
    assign fire[i]   = mif.eq[i] & ~mif.prev[i];
    assign mif.irq_set[i] = fire[i] & mif.match_action_control[B + ptm_pkg::MCR_IRQ_OFS];
    assign rst_v[i]  = fire[i] & mif.match_action_control[B + ptm_pkg::MCR_RST_OFS];
    assign stop_v[i] = fire[i] & mif.match_action_control[B + ptm_pkg::MCR_STOP_OFS];
  end

  assign mif.reset_hit = |rst_v;
  assign mif.stop_hit  = |stop_v;

endmodule // ptm_match_unit
`default_nettype wire

// >>> src/ptm_pkg.sv
`default_nettype none
package ptm_pkg;

  localparam int unsigned NUM_MATCH    = 3;
  localparam int unsigned MCR_STRIDE   = 3;
  localparam int unsigned MCR_IRQ_OFS  = 0;
  localparam int unsigned MCR_RST_OFS  = 1;
  localparam int unsigned MCR_STOP_OFS = 2;
  localparam int unsigned MCR_WIDTH    = 9;
  localparam int unsigned TCR_EN_BIT   = 0;
  localparam int unsigned TCR_RST_BIT  = 1;

  localparam logic [31:0] ADDR_FLAGS   = 32'h4001_4000;
  localparam logic [31:0] ADDR_CTRL    = 32'h4001_4004;
  localparam logic [31:0] ADDR_COUNT   = 32'h4001_4008;
  localparam logic [31:0] ADDR_PLIM    = 32'h4001_400c;
  localparam logic [31:0] ADDR_PCNT    = 32'h4001_4010;
  localparam logic [31:0] ADDR_MCR     = 32'h4001_4014;
  localparam logic [31:0] ADDR_MV0     = 32'h4001_4018;
  localparam logic [31:0] ADDR_MV1     = 32'h4001_401c;
  localparam logic [31:0] ADDR_MV2     = 32'h4001_4020;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [31:0] COUNT_MAX     = 32'hffff_ffff;
  localparam logic [31:0] COUNT_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RD_WAIT,
    BUS_RD_DONE
  } ptm_bus_t;

  typedef enum logic [3:0] {
    REG_NONE,
    REG_FLAGS,
    REG_CTRL,
    REG_COUNT,
    REG_PLIM,
    REG_PCNT,
    REG_MCR,
    REG_MV0,
    REG_MV1,
    REG_MV2
  } ptm_reg_t;

  typedef struct packed {
    logic                            en;
    logic                            counter_reset_bit;
    logic [31:0]                     tc;
    logic [31:0]                     pc;
    logic [31:0]                     pr;
    logic [MCR_WIDTH-1:0]            match_action_control;
    logic [NUM_MATCH-1:0][31:0]      mr;
    logic [NUM_MATCH-1:0]            flags;
    logic [NUM_MATCH-1:0]            prev;
    ptm_bus_t                        bus;
    ptm_reg_t                        sel;
    logic [31:0]                     rdata;
  } ptm_state_t;

  localparam ptm_state_t STATE_RESET = '0;

  function automatic ptm_reg_t reg_decode(input logic [31:0] a);
    case (a)
      ADDR_FLAGS: return REG_FLAGS;
      ADDR_CTRL:  return REG_CTRL;
      ADDR_COUNT: return REG_COUNT;
      ADDR_PLIM:  return REG_PLIM;
      ADDR_PCNT:  return REG_PCNT;
      ADDR_MCR:   return REG_MCR;
      ADDR_MV0:   return REG_MV0;
      ADDR_MV1:   return REG_MV1;
      ADDR_MV2:   return REG_MV2;
      default:    return REG_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> src/ptm_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Main count is 32 bits, advancing only at prescale terminal value.
// - Main count wraps from all ones to zero on next increment.
// - Main count wrap raises no flag; use a match channel instead.
// - Prescale limit register sets highest prescale count value.
// - Prescale counter increments every clock while counting is enabled.
// - At limit, main count increments and prescale counter returns to zero.
// - Main count advances once every limit plus one clocks.
// - Match control bits 0,3,6 let a match set channel flags.
// - Match control bits 1,4,7 let a match reset the main count.
// - Bits 2,5,8 let a match halt counters and clear enable.
// - Counters advance only while control enable bit 0 is one.
// - While control bit 1 is one both counters clear each edge.
// - Flags read one when pending; write one clears, zero keeps.
// - Match values are compared with main count continuously.
module ptm_timer (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  output logic [2:0]        match_flags
);

  ptm_pkg::ptm_state_t st;
  ptm_pkg::ptm_state_t nx;

  logic                          ce;
  logic                          term;
  logic                          addr_ok;
  logic                          wr_en;
  logic [ptm_pkg::NUM_MATCH-1:0] clr;
  logic                          wr_cnt;
  logic [31:0]                   rd_val;

  ptm_match_if mif ();

  ptm_match_unit u_match (
    .mif (mif.unit)
  );

  assign mif.tc   = st.tc;
  assign mif.mr   = st.mr;
  assign mif.match_action_control  = st.match_action_control;
  assign mif.prev = st.prev;

  assign ce      = st.en & ~st.counter_reset_bit;
  assign term    = (st.pc == st.pr);
  // Only whole-word single transfers are used; hsize is not checked
  assign addr_ok = hsel & hready & (htrans == ptm_pkg::HTRANS_NONSEQ);
  assign wr_en   = (st.bus == ptm_pkg::BUS_WRITE);
  assign wr_cnt  = wr_en & ((st.sel == ptm_pkg::REG_COUNT) |
                            (st.sel == ptm_pkg::REG_PCNT));

  assign clr = (wr_en && st.sel == ptm_pkg::REG_FLAGS) ?
               hwdata[ptm_pkg::NUM_MATCH-1:0] : 3'h0;

  // Reads take one wait state so they see writes of the prior transfer
  assign hreadyout   = (st.bus != ptm_pkg::BUS_RD_WAIT);
  assign hrdata      = st.rdata;
  assign hresp       = ptm_pkg::HRESP_OKAY;
  assign match_flags = st.flags;

  always_comb
  begin
    rd_val = 32'h0;
    case (st.sel)
      ptm_pkg::REG_FLAGS: rd_val = {29'h0, st.flags};
      ptm_pkg::REG_CTRL:  rd_val = {30'h0, st.counter_reset_bit, st.en};
      ptm_pkg::REG_COUNT: rd_val = st.tc;
      ptm_pkg::REG_PLIM:  rd_val = st.pr;
      ptm_pkg::REG_PCNT:  rd_val = st.pc;
      ptm_pkg::REG_MCR:   rd_val = {23'h0, st.match_action_control};
      ptm_pkg::REG_MV0:   rd_val = st.mr[0];
      ptm_pkg::REG_MV1:   rd_val = st.mr[1];
      ptm_pkg::REG_MV2:   rd_val = st.mr[2];
      default:            rd_val = 32'h0;
    endcase
  end

  always_comb
  begin
    nx = st;
    nx.prev = mif.eq;

    // Set wins over a clear in the same cycle
    nx.flags = (st.flags & ~clr) | mif.irq_set;

    case (st.bus)
      ptm_pkg::BUS_RD_WAIT:
      begin
        nx.rdata = rd_val;
        nx.bus   = ptm_pkg::BUS_RD_DONE;
      end
      ptm_pkg::BUS_IDLE, ptm_pkg::BUS_WRITE, ptm_pkg::BUS_RD_DONE:
      begin
        if (addr_ok)
        begin
          nx.sel = ptm_pkg::reg_decode(haddr);
          nx.bus = hwrite ? ptm_pkg::BUS_WRITE : ptm_pkg::BUS_RD_WAIT;
        end
        else
        begin
          nx.sel = ptm_pkg::REG_NONE;
          nx.bus = ptm_pkg::BUS_IDLE;
        end
      end
      default:
      begin
        nx.bus = ptm_pkg::BUS_IDLE;
      end
    endcase

    if (wr_en)
    begin
      case (st.sel)
        ptm_pkg::REG_CTRL:
        begin
          nx.en   = hwdata[ptm_pkg::TCR_EN_BIT];
          nx.counter_reset_bit = hwdata[ptm_pkg::TCR_RST_BIT];
        end
        ptm_pkg::REG_PLIM: nx.pr = hwdata;
        ptm_pkg::REG_MCR:  nx.match_action_control = hwdata[ptm_pkg::MCR_WIDTH-1:0];
        ptm_pkg::REG_MV0:  nx.mr[0] = hwdata;
        ptm_pkg::REG_MV1:  nx.mr[1] = hwdata;
        ptm_pkg::REG_MV2:  nx.mr[2] = hwdata;
        default:           nx.mr = st.mr;
      endcase
    end

    // Hardware stop overrides a same-cycle software enable
    if (mif.stop_hit)
    begin
      nx.en = 1'b0;
    end

    if (st.counter_reset_bit)
    begin
      // Reset bit beats bus writes and matches
      nx.tc = ptm_pkg::COUNT_ZERO;
      nx.pc = ptm_pkg::COUNT_ZERO;
    end
    else
    begin
      if (ce && !mif.stop_hit)
      begin
        if (term)
        begin
          nx.pc = ptm_pkg::COUNT_ZERO;
          nx.tc = st.tc + 32'h1;
        end
        else
        begin
          nx.pc = st.pc + 32'h1;
        end
      end
      if (mif.reset_hit)
      begin
        nx.tc = ptm_pkg::COUNT_ZERO;
      end
      if (wr_en && st.sel == ptm_pkg::REG_COUNT)
      begin
        nx.tc = hwdata;
      end
      if (wr_en && st.sel == ptm_pkg::REG_PCNT)
      begin
        nx.pc = hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= ptm_pkg::STATE_RESET;
    end
    else
    begin
      st <= nx;
    end
  end

  logic quiet;
  logic [2:0] irq_gate;

  assign quiet    = ce & ~mif.reset_hit & ~mif.stop_hit & ~wr_cnt &
                    ~(wr_en && st.sel == ptm_pkg::REG_CTRL);
  assign irq_gate = mif.irq_set;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_quiet_at_zero;
    quiet && st.pr == 32'h1 && st.pc == 32'h0;
  endsequence

  sequence s_two_quiet;
    s_quiet_at_zero ##1 (quiet && st.pr == 32'h1);
  endsequence

  sequence s_stop_held;
    !st.en && st.pc == $past(st.pc) ##1 st.pc == $past(st.pc, 2);
  endsequence

  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_tc_step: assert property (
    (quiet && term) |=> (st.tc == $past(st.tc) + 32'h1) && st.pc == 32'h0
  ) else $error("main count did not step at prescale limit");

  a_tc_wrap_zero: assert property (
    (quiet && term && st.tc == ptm_pkg::COUNT_MAX) |=> st.tc == 32'h0
  ) else $error("main count did not wrap to zero");

  a_wrap_no_flag: assert property (
    (quiet && term && st.tc == ptm_pkg::COUNT_MAX && irq_gate == 3'h0)
      |=> (st.flags & ~$past(st.flags)) == 3'h0
  ) else $error("wrap raised a flag");

  a_pc_increment: assert property (
    (quiet && !term) |=> st.pc == $past(st.pc) + 32'h1 &&
                         st.tc == $past(st.tc)
  ) else $error("prescale counter did not increment");

  a_period_two: assert property (
    s_two_quiet |=> st.tc == $past(st.tc, 2) + 32'h1 && st.pc == 32'h0
  ) else $error("limit one did not give a two clock period");

  a_match_flag: assert property (
    (irq_gate != 3'h0) |=> (st.flags & $past(irq_gate)) == $past(irq_gate)
  ) else $error("enabled match did not set its flag");

  a_match_reset: assert property (
    (mif.reset_hit && !st.counter_reset_bit && !wr_cnt) |=> st.tc == 32'h0
  ) else $error("reset on match did not clear main count");

  a_match_stop: assert property (
    (mif.stop_hit && !st.counter_reset_bit && !wr_cnt)
      |=> s_stop_held
  ) else $error("stop on match did not halt counters");

  a_both_actions: assert property (
    (mif.reset_hit && mif.stop_hit && !st.counter_reset_bit && !wr_cnt)
      |=> st.tc == 32'h0 && !st.en
  ) else $error("reset and stop not applied together");

  a_disabled_hold: assert property (
    (!st.en && !mif.reset_hit && !wr_cnt)
      |=> $past(st.counter_reset_bit) ? (st.pc == 32'h0 && st.tc == 32'h0) :
                           ($stable(st.pc) && $stable(st.tc))
  ) else $error("counters moved while disabled");

  a_counter_reset_bit_clear: assert property (
    st.counter_reset_bit |=> st.tc == 32'h0 && st.pc == 32'h0
  ) else $error("counter reset bit did not clear counters");

  a_flag_clear: assert property (
    ((clr & ~irq_gate) != 3'h0)
      |=> (st.flags & $past(clr & ~irq_gate)) == 3'h0
  ) else $error("write one did not clear flag");

  a_read_wait: assert property (
    (addr_ok && !hwrite) |=> s_read_wait
  ) else $error("read did not take exactly one wait state");

  a_plim_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_PLIM) |=> st.pr == $past(hwdata)
  ) else $error("prescale limit write did not land");

  a_read_plim: assert property (
    (st.bus == ptm_pkg::BUS_RD_WAIT && st.sel == ptm_pkg::REG_PLIM)
      |=> hrdata == $past(st.pr)
  ) else $error("prescale limit read back wrong");

  a_tc_cause: assert property (
    (!st.counter_reset_bit && !mif.reset_hit && !wr_cnt && !(ce && term))
      |=> $stable(st.tc)
  ) else $error("main count moved between prescale limits");

  a_tc_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_COUNT && !st.counter_reset_bit)
      |=> st.tc == $past(hwdata)
  ) else $error("main count write did not land");

  a_pc_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_PCNT && !st.counter_reset_bit)
      |=> st.pc == $past(hwdata)
  ) else $error("prescale count write did not land");

  a_ctrl_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_CTRL && !mif.stop_hit)
      |=> st.en == $past(hwdata[ptm_pkg::TCR_EN_BIT]) &&
          st.counter_reset_bit == $past(hwdata[ptm_pkg::TCR_RST_BIT])
  ) else $error("control write did not land");

  a_mcr_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_MCR)
      |=> st.match_action_control == $past(hwdata[ptm_pkg::MCR_WIDTH-1:0])
  ) else $error("match control write did not land");

  a_mv_write: assert property (
    (wr_en && st.sel == ptm_pkg::REG_MV0) |=> st.mr[0] == $past(hwdata)
  ) else $error("match value write did not land");

  a_entry_flag: assert property (
    (st.tc == st.mr[0] && !st.prev[0] && st.match_action_control[ptm_pkg::MCR_IRQ_OFS])
      |=> st.flags[0]
  ) else $error("entry into equality did not set flag");

  a_flag_cause: assert property (
    (irq_gate == 3'h0) |=> (st.flags & ~$past(st.flags)) == 3'h0
  ) else $error("flag rose without an enabled match");

  a_flag_keep: assert property (
    (clr == 3'h0) |=> (st.flags & $past(st.flags)) == $past(st.flags)
  ) else $error("pending flag lost without a write one");

  a_stop_clears_en: assert property (
    mif.stop_hit |=> !st.en
  ) else $error("stop on match left counting enabled");

  a_rdata_stands: assert property (
    (st.bus != ptm_pkg::BUS_RD_WAIT) |=> $stable(hrdata)
  ) else $error("read data changed outside a read");

  a_unmapped_zero: assert property (
    (st.bus == ptm_pkg::BUS_RD_WAIT && st.sel == ptm_pkg::REG_NONE)
      |=> hrdata == 32'h0
  ) else $error("unmapped address read nonzero");

endmodule // ptm_timer
`default_nettype wire
